// ===== inc/ubm_pkg.sv
package ubm_pkg;

  // Instruction word layout
  localparam int          INSTR_W      = 16;
  localparam int          OPC_LIT_LSB  = 8;
  localparam int          OPC_FILE_LSB = 9;
  localparam int          ACC_SEL_BIT  = 8;
  localparam int          FIELD_W      = 8;
  localparam logic [7:0]  LIT_OPC      = 8'h0d;
  localparam logic [6:0]  FILE_OPC     = 7'h01;

  // Data memory addressing
  localparam int          ADDR_W       = 12;
  localparam int          BANK_W       = 4;
  localparam logic [7:0]  IDX_MAX      = 8'h5f;
  localparam logic [7:0]  ACC_SPLIT    = 8'h60;
  localparam logic [3:0]  ACC_LO_BANK  = 4'h0;
  localparam logic [3:0]  ACC_HI_BANK  = 4'hf;

  // Product and reset values
  localparam int          PROD_W       = 16;
  localparam logic [15:0] INSTR_RST    = 16'h0000;
  localparam logic [15:0] PROD_RST     = 16'h0000;
  localparam logic [7:0]  BYTE_RST     = 8'h00;
  localparam logic [11:0] ADDR_RST     = 12'h000;

  // Clock and phase timing
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          PHASE_NS      = 50;
  localparam int          PHASE_CYCLES  = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    PH_DECODE,
    PH_READ,
    PH_PROC,
    PH_WRITE
  } ubm_phase_t;

endpackage

// ===== src/ubm_mult.sv
`timescale 1ns/1ps

module ubm_mult (
  // Operands
  input  wire logic [7:0]  a_in,
  input  wire logic [7:0]  b_in,
  // Result
  output logic      [15:0] prod_out
);

  // Zero-extend so the product keeps all sixteen bits
  wire logic [15:0] a_ext;
  wire logic [15:0] b_ext;

  assign a_ext    = {8'h00, a_in};
  assign b_ext    = {8'h00, b_in};
  assign prod_out = a_ext * b_ext;

endmodule

// ===== src/ubm_decode.sv
`timescale 1ns/1ps

module ubm_decode (
  // Instruction and address context
  input  wire logic [15:0] instr_in,
  input  wire logic [3:0]  bank_select_reg_in,
  input  wire logic [11:0] fsr2_in,
  input  wire logic        ext_set_en_in,
  // Decode results
  output logic             is_lit_out,
  output logic             is_file_out,
  output logic      [11:0] addr_out
);

  wire logic [7:0] opc_hi;
  wire logic [6:0] opc_file;
  wire logic [7:0] faddr;
  wire logic       acc_sel;
  wire logic       indexed;
  wire logic       acc_low;
  wire logic [11:0] idx_addr;
  wire logic [11:0] acc_addr;
  wire logic [11:0] bank_addr;

  assign opc_hi   = instr_in[ubm_pkg::INSTR_W-1:ubm_pkg::OPC_LIT_LSB];
  assign opc_file = instr_in[ubm_pkg::INSTR_W-1:ubm_pkg::OPC_FILE_LSB];
  assign faddr    = instr_in[ubm_pkg::FIELD_W-1:0];
  assign acc_sel  = instr_in[ubm_pkg::ACC_SEL_BIT];

  assign is_lit_out  = (opc_hi == ubm_pkg::LIT_OPC);
  assign is_file_out = (opc_file == ubm_pkg::FILE_OPC);

  // Indexed literal offset: FSR2 plus the short offset
  assign indexed  = ext_set_en_in && !acc_sel && (faddr <= ubm_pkg::IDX_MAX);
  assign idx_addr = fsr2_in + {4'h0, faddr};

  // Access bank: low part of bank 0 or top of the last bank
  assign acc_low  = (faddr < ubm_pkg::ACC_SPLIT);
  assign acc_addr = acc_low ? {ubm_pkg::ACC_LO_BANK, faddr}
                            : {ubm_pkg::ACC_HI_BANK, faddr};
  assign bank_addr = {bank_select_reg_in, faddr};

  assign addr_out = indexed  ? idx_addr :
                    !acc_sel ? acc_addr : bank_addr;

endmodule

// ===== src/ubm_core.sv
// Notes on behaviour
// - Literal form multiplies W by immediate byte
// - Full product: high byte, low byte pair
// - File form multiplies W by memory byte
// - W and memory operand stay unchanged
// - No status flag is ever written
// - Literal opcode: upper byte 0000 1101
// - File opcode: 0000 001, access bit, address
// - Access bit 0 selects access bank
// - Access bit 1 uses bank select register
// - Extended set, a=0, f<=95: indexed offset
// - One cycle: decode, read, process, write
`timescale 1ns/1ps

module ubm_core (
  // Clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              arst_n_in,
  // Instruction from fetch, valid in the decode phase
  input  wire logic [15:0]       instr_in,
  // Core state feeding operands and addressing
  input  wire logic [7:0]        w_in,
  input  wire logic [3:0]        bank_select_reg_in,
  input  wire logic [11:0]       fsr2_in,
  input  wire logic              ext_set_en_in,
  // Data memory read port
  output logic                   mem_rd_out,
  output logic      [11:0]       mem_addr_out,
  input  wire logic [7:0]        mem_rdata_in,
  // Write enables towards the rest of the core
  output logic                   mem_we_out,
  output logic                   w_we_out,
  output logic                   status_we_out,
  // Product register pair
  output logic                   prod_we_out,
  output logic      [7:0]        product_high_byte_out,
  output logic      [7:0]        product_low_byte_out,
  // Phase and activity
  output ubm_pkg::ubm_phase_t    phase_out,
  output logic                   mul_busy_out
);

  ubm_pkg::ubm_phase_t phase_r;
  ubm_pkg::ubm_phase_t phase_nxt;

  logic [15:0] instr_r;
  logic        lit_r;
  logic        file_r;
  logic [11:0] addr_r;
  logic [7:0]  w_op_r;
  logic [7:0]  b_op_r;
  logic [15:0] res_r;
  logic [7:0]  prod_hi_r;
  logic [7:0]  prod_lo_r;

  wire logic        dec_lit;
  wire logic        dec_file;
  wire logic [11:0] dec_addr;
  wire logic [15:0] mul_prod;
  wire logic        ph_decode;
  wire logic        ph_read;
  wire logic        ph_proc;
  wire logic        ph_write;
  wire logic        mul_op;
  wire logic [7:0]  lit_val;
  wire logic [7:0]  b_op_nxt;

  // Phase sequencer
  always_comb begin
    unique case (phase_r)
      ubm_pkg::PH_DECODE: phase_nxt = ubm_pkg::PH_READ;
      ubm_pkg::PH_READ:   phase_nxt = ubm_pkg::PH_PROC;
      ubm_pkg::PH_PROC:   phase_nxt = ubm_pkg::PH_WRITE;
      ubm_pkg::PH_WRITE:  phase_nxt = ubm_pkg::PH_DECODE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      phase_r <= ubm_pkg::PH_DECODE;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  assign ph_decode = (phase_r == ubm_pkg::PH_DECODE);
  assign ph_read   = (phase_r == ubm_pkg::PH_READ);
  assign ph_proc   = (phase_r == ubm_pkg::PH_PROC);
  assign ph_write  = (phase_r == ubm_pkg::PH_WRITE);
  assign mul_op    = lit_r || file_r;

  ubm_decode u_decode (
    .instr_in           (instr_in),
    .bank_select_reg_in (bank_select_reg_in),
    .fsr2_in            (fsr2_in),
    .ext_set_en_in      (ext_set_en_in),
    .is_lit_out         (dec_lit),
    .is_file_out        (dec_file),
    .addr_out           (dec_addr)
  );

  // Decode phase: capture the word and the operand address
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      instr_r <= ubm_pkg::INSTR_RST;
      lit_r   <= 1'b0;
      file_r  <= 1'b0;
      addr_r  <= ubm_pkg::ADDR_RST;
    end else if (ph_decode) begin
      instr_r <= instr_in;
      lit_r   <= dec_lit;
      file_r  <= dec_file;
      addr_r  <= dec_addr;
    end
  end

  // Read phase: literal from the word, or the addressed byte
  assign lit_val  = instr_r[ubm_pkg::FIELD_W-1:0];
  assign b_op_nxt = file_r ? mem_rdata_in : lit_val;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      w_op_r <= ubm_pkg::BYTE_RST;
      b_op_r <= ubm_pkg::BYTE_RST;
    end else if (ph_read) begin
      w_op_r <= w_in;
      b_op_r <= b_op_nxt;
    end
  end

  ubm_mult u_mult (
    .a_in     (w_op_r),
    .b_in     (b_op_r),
    .prod_out (mul_prod)
  );

  // Process phase: product held ready for the write phase
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      res_r <= ubm_pkg::PROD_RST;
    end else if (ph_proc) begin
      res_r <= mul_prod;
    end
  end

  // Write phase: load the product pair
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prod_hi_r <= ubm_pkg::BYTE_RST;
      prod_lo_r <= ubm_pkg::BYTE_RST;
    end else if (ph_write && mul_op) begin
      prod_hi_r <= res_r[ubm_pkg::PROD_W-1:ubm_pkg::FIELD_W];
      prod_lo_r <= res_r[ubm_pkg::FIELD_W-1:0];
    end
  end

  assign mem_rd_out    = ph_read && file_r;
  assign mem_addr_out  = addr_r;
  assign prod_we_out   = ph_write && mul_op;
  // Multiplies never write back sources or flags
  assign mem_we_out    = 1'b0;
  assign w_we_out      = 1'b0;
  assign status_we_out = 1'b0;
  assign product_high_byte_out = prod_hi_r;
  assign product_low_byte_out  = prod_lo_r;
  assign phase_out     = phase_r;
  assign mul_busy_out  = mul_op && !ph_decode;

  // Checks
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!arst_n_in);

  sequence s_lit_in_decode;
    ph_decode && (instr_in[15:8] == ubm_pkg::LIT_OPC);
  endsequence

  sequence s_file_in_decode;
    ph_decode && (instr_in[15:9] == ubm_pkg::FILE_OPC);
  endsequence

  sequence s_mul_cycle;
    ph_read && mul_op ##1 ph_proc && mul_op ##1 prod_we_out;
  endsequence

  sequence s_file_access;
    s_file_in_decode ##0 !instr_in[ubm_pkg::ACC_SEL_BIT];
  endsequence

  sequence s_plain_in_decode;
    ph_decode && (instr_in[ubm_pkg::INSTR_W-1:ubm_pkg::OPC_LIT_LSB] != ubm_pkg::LIT_OPC)
      && (instr_in[ubm_pkg::INSTR_W-1:ubm_pkg::OPC_FILE_LSB] != ubm_pkg::FILE_OPC);
  endsequence

  property p_lit_product;
    ph_read && lit_r |-> ##3
      {product_high_byte_out, product_low_byte_out}
        == 16'($past(w_in, 3)) * 16'(instr_r[7:0]);
  endproperty

  property p_file_product;
    ph_read && file_r |-> ##3
      {product_high_byte_out, product_low_byte_out}
        == 16'($past(w_in, 3)) * 16'($past(mem_rdata_in, 3));
  endproperty

  chk_lit_product_value: assert property (p_lit_product)
    else $error("literal product wrong");

  chk_pair_byte_split: assert property (
    prod_we_out |=> product_high_byte_out == $past(res_r[15:8])
                 && product_low_byte_out == $past(res_r[7:0]))
    else $error("product pair split wrong");

  chk_file_product_value: assert property (p_file_product)
    else $error("file product wrong");

  chk_sources_kept: assert property (
    mul_op && !ph_decode |-> !w_we_out && !mem_we_out)
    else $error("multiply wrote a source operand");

  chk_flags_untouched: assert property (
    (mul_op && prod_we_out) or (mul_busy_out) |-> !status_we_out)
    else $error("multiply wrote status flags");

  chk_lit_decode_hit: assert property (
    s_lit_in_decode |=> lit_r && !file_r ##2 prod_we_out)
    else $error("literal opcode not decoded");

  chk_file_decode_hit: assert property (
    s_file_in_decode |=> file_r && mem_rd_out)
    else $error("file opcode not decoded");

  chk_access_bank_addr: assert property (
    s_file_access ##0 !(ext_set_en_in && instr_in[7:0] <= ubm_pkg::IDX_MAX)
      |=> mem_addr_out == (($past(instr_in[7:0]) < ubm_pkg::ACC_SPLIT)
            ? {ubm_pkg::ACC_LO_BANK, $past(instr_in[7:0])}
            : {ubm_pkg::ACC_HI_BANK, $past(instr_in[7:0])}))
    else $error("access bank address wrong");

  chk_bank_select_addr: assert property (
    s_file_in_decode ##0 instr_in[ubm_pkg::ACC_SEL_BIT]
      |=> mem_addr_out == {$past(bank_select_reg_in), $past(instr_in[7:0])})
    else $error("banked address wrong");

  chk_indexed_addr: assert property (
    s_file_access ##0 ext_set_en_in && instr_in[7:0] <= ubm_pkg::IDX_MAX
      |=> mem_addr_out == 12'($past(fsr2_in) + 12'($past(instr_in[7:0]))))
    else $error("indexed offset address wrong");

  chk_one_cycle_seq: assert property (
    (s_lit_in_decode or s_file_in_decode) |=> s_mul_cycle)
    else $error("multiply not done in one cycle");

  chk_res_settled: assert property (
    prod_we_out |-> $stable(w_op_r) && $stable(b_op_r)
                 && res_r == 16'(w_op_r) * 16'(b_op_r))
    else $error("product not settled before write");

  chk_phase_rotation: assert property (
    ph_decode |=> ph_read ##1 ph_proc ##1 ph_write ##1 ph_decode)
    else $error("phase order broken");

  chk_read_strobe_phase: assert property (
    mem_rd_out |-> ph_read && file_r && !lit_r)
    else $error("memory read outside read phase");

  chk_write_pulse_phase: assert property (
    prod_we_out |-> ph_write ##1 ph_decode && !prod_we_out)
    else $error("product write outside write phase");

  chk_product_hold: assert property (
    !prod_we_out |=> $stable(product_high_byte_out) && $stable(product_low_byte_out))
    else $error("product pair changed without a write");

  chk_lit_busy_span: assert property (
    s_lit_in_decode |=> (mul_busy_out && !mem_rd_out) [*3] ##1 !mul_busy_out)
    else $error("literal multiply busy span wrong");

  chk_plain_word_idle: assert property (
    s_plain_in_decode |=> !mul_busy_out && !mem_rd_out ##2 !prod_we_out)
    else $error("non-multiply word started a multiply");

  chk_addr_held: assert property (
    !ph_decode |=> $stable(mem_addr_out))
    else $error("operand address moved mid-cycle");

  chk_file_read_span: assert property (
    s_file_in_decode |=> mem_rd_out && mul_busy_out ##1 (!mem_rd_out && mul_busy_out) [*2]
      ##1 (!mem_rd_out && !mul_busy_out))
    else $error("file multiply read span wrong");

  chk_operand_capture: assert property (
    ph_read && mul_op |=> w_op_r == $past(w_in)
      && b_op_r == (file_r ? $past(mem_rdata_in) : instr_r[ubm_pkg::FIELD_W-1:0]))
    else $error("operand capture wrong");

  chk_decode_no_strobe: assert property (
    ph_decode |-> !mem_rd_out && !prod_we_out && !mul_busy_out)
    else $error("strobe active in decode phase");

  chk_zero_product_flags: assert property (
    prod_we_out && res_r == ubm_pkg::PROD_RST |-> !status_we_out)
    else $error("zero product touched status flags");

endmodule

// ===== bench/ubm_mem_model.sv
`timescale 1ns/1ps

module ubm_mem_model (
  // Clock
  input  wire logic        clk_sys_in,
  // Read port
  input  wire logic        mem_rd_in,
  input  wire logic [11:0] mem_addr_in,
  output logic      [7:0]  mem_rdata_out
);
  logic [7:0] mem_r [4096];
  logic [7:0] last_r;

  initial begin
    last_r = 8'h5a;
    for (int i = 0; i < 4096; i++) begin
      mem_r[i] = 8'(i) ^ {4'(i >> 8), 4'(i >> 8)};
    end
  end

  // Bus not read shows inverse of last byte
  assign mem_rdata_out = mem_rd_in ? mem_r[mem_addr_in] : ~last_r;

  always @(posedge clk_sys_in) begin
    if (mem_rd_in) begin
      last_r <= mem_r[mem_addr_in];
    end
  end
endmodule

// ===== bench/testbench.sv
`timescale 1ns/1ps

`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

module testbench;
  logic                clk_sys_in = 1'b0;
  logic                arst_n_in  = 1'b0;
  logic [15:0]         instr      = 16'h0000;
  logic [7:0]          w          = 8'h00;
  logic [3:0]          bank_sel   = 4'h0;
  logic [11:0]         fsr2       = 12'h000;
  logic                ext        = 1'b0;
  logic                mem_rd;
  logic [11:0]         mem_addr;
  logic [7:0]          mem_rdata;
  logic                mem_we;
  logic                w_we;
  logic                status_we;
  logic                prod_we;
  logic [7:0]          prod_hi;
  logic [7:0]          prod_lo;
  ubm_pkg::ubm_phase_t phase;
  logic                busy;
  wire  [15:0]         prod = {prod_hi, prod_lo};
  int                  num_errors = 0;
  int                  n_checks = 0;
  int                  cyc = 0;

  ubm_core i_dut (
    .clk_sys_in            (clk_sys_in),
    .arst_n_in             (arst_n_in),
    .instr_in              (instr),
    .w_in                  (w),
    .bank_select_reg_in    (bank_sel),
    .fsr2_in               (fsr2),
    .ext_set_en_in         (ext),
    .mem_rd_out            (mem_rd),
    .mem_addr_out          (mem_addr),
    .mem_rdata_in          (mem_rdata),
    .mem_we_out            (mem_we),
    .w_we_out              (w_we),
    .status_we_out         (status_we),
    .prod_we_out           (prod_we),
    .product_high_byte_out (prod_hi),
    .product_low_byte_out  (prod_lo),
    .phase_out             (phase),
    .mul_busy_out          (busy)
  );

  ubm_mem_model i_mem (
    .clk_sys_in    (clk_sys_in),
    .mem_rd_in     (mem_rd),
    .mem_addr_in   (mem_addr),
    .mem_rdata_out (mem_rdata)
  );

  initial begin
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc >= 1000) begin
      num_errors++;
      report_and_stop();
    end
  end

  function automatic logic [7:0] mem_byte(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]};
  endfunction

  task automatic step();
    @(posedge clk_sys_in);
    #1;
  endtask

  // One instruction cycle, entered and left in the decode phase
  task automatic run_op(input logic [15:0] ins, input logic [7:0] wv, input logic [3:0] bs,
                        input logic [11:0] fs, input logic ex, input logic [11:0] ea);
    logic        is_lit;
    logic        is_file;
    logic [15:0] exp;
    is_lit  = (ins[15:8] == 8'h0d);
    is_file = (ins[15:9] == 7'h01);
    exp = is_lit ? 16'(wv) * 16'(ins[7:0]) : is_file ? 16'(wv) * 16'(mem_byte(ea)) : prod;
    `CHK(phase, ubm_pkg::PH_DECODE)
    instr = ins;
    w     = wv;
    bank_sel = bs;
    fsr2  = fs;
    ext   = ex;
    step();
    `CHK(mem_rd, is_file)
    if (is_file) `CHK(mem_addr, ea)
    `CHK(busy, is_lit | is_file)
    step();
    `CHK(prod_we, 1'b0)
    step();
    `CHK(prod_we, is_lit | is_file)
    `CHK({mem_we, w_we, status_we}, 3'h0)
    step();
    `CHK(prod, exp)
  endtask

  task automatic t_literal();
    run_op(16'h0dc4, 8'he2, 4'h0, 12'h000, 1'b0, 12'h000);
    run_op(16'h0dff, 8'hff, 4'h0, 12'h000, 1'b1, 12'h000);
    run_op(16'h0d00, 8'h37, 4'h0, 12'h000, 1'b0, 12'h000);
    $display("done literal");
  endtask

  task automatic t_banked();
    run_op(16'h0312, 8'hc4, 4'h5, 12'h000, 1'b0, 12'h512);
    run_op(16'h03ff, 8'hff, 4'hf, 12'h000, 1'b1, 12'hfff);
    $display("done banked");
  endtask

  task automatic t_access();
    run_op(16'h0210, 8'h9c, 4'h7, 12'h000, 1'b0, 12'h010);
    run_op(16'h025f, 8'h81, 4'h7, 12'h400, 1'b0, 12'h05f);
    run_op(16'h0260, 8'h13, 4'h7, 12'h400, 1'b0, 12'hf60);
    $display("done access");
  endtask

  task automatic t_indexed();
    run_op(16'h025f, 8'h21, 4'h3, 12'hfe0, 1'b1, 12'h03f);
    run_op(16'h0260, 8'h77, 4'h3, 12'h123, 1'b1, 12'hf60);
    run_op(16'h0200, 8'hf0, 4'h3, 12'h123, 1'b1, 12'h123);
    $display("done indexed");
  endtask

  task automatic t_non_mul();
    run_op(16'h0e12, 8'h55, 4'h1, 12'h000, 1'b0, 12'h000);
    run_op(16'h0c34, 8'h55, 4'h1, 12'h000, 1'b0, 12'h000);
    run_op(16'h0480, 8'h55, 4'h1, 12'h000, 1'b0, 12'h000);
    $display("done non-multiply");
  endtask

  task automatic t_reset();
    instr = 16'h0d99;
    w     = 8'h99;
    step();
    arst_n_in = 1'b0;
    #1;
    `CHK(prod, 16'h0000)
    `CHK(phase, ubm_pkg::PH_DECODE)
    `CHK({mem_rd, busy, prod_we}, 3'h0)
    step();
    arst_n_in = 1'b1;
    run_op(16'h0d02, 8'h80, 4'h0, 12'h000, 1'b0, 12'h000);
    $display("done reset");
  endtask

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk_sys_in);
    #1;
    arst_n_in = 1'b1;
    t_literal();
    t_banked();
    t_access();
    t_indexed();
    t_non_mul();
    t_reset();
    report_and_stop();
  end
endmodule
